// ---- test_wakeup_timer_unit.sv ----
// Self-checking bench for the wake-up timer unit.
// Assumes wut_top with a short calibration count; inputs move at negedge.
`timescale 1ns/10ps
`include "wut_regs.svh"
module test_wakeup_timer_unit;
	import wut_pkg::*;
	localparam int CAL = 20;
	logic ref_clk = 0, srst = 1, rc_clk = 0, xt_clk = 0;
	logic reg_wr = 0, reg_rd = 0, cmd_valid = 0;
	logic [10:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, cmd_code = 0, reg_rdata;
	logic irq1, irq2, sleeping, wake_event;
	int fail_count = 0, check_count = 0;
	int divs [6] = '{1, 4, 8, 16, 128, 1024};

	wut_top #(.CAL_CYCLES(CAL)) dut (.ref_clk(ref_clk), .srst(srst),
		.rc_osc_clk(rc_clk), .xtal_osc_clk(xt_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.irq1(irq1), .irq2(irq2), .sleeping(sleeping),
		.wake_event(wake_event));

	// 250 MHz system clock
	initial forever #2 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// One-cycle strobes; each task starts and ends on a falling edge
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge ref_clk);
		reg_wr = 0;
	endtask : wr

	task automatic rd(input logic [10:0] a, input logic [7:0] exp);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1;
		@(negedge ref_clk);
		reg_rd = 0;
		check(reg_rdata, exp);
	endtask : rd

	task automatic cmd(input logic [7:0] c);
		@(negedge ref_clk);
		cmd_code = c;
		cmd_valid = 1;
		@(negedge ref_clk);
		cmd_valid = 0;
	endtask : cmd

	// Low dwell of 6 cycles lets the 3-flop synchroniser see each edge
	task automatic slow_edge(input logic xt);
		if (xt) xt_clk = 1; else rc_clk = 1;
		repeat (6) @(negedge ref_clk);
		xt_clk = 0;
		rc_clk = 0;
		repeat (6) @(negedge ref_clk);
	endtask : slow_edge

	// Clock source first, then reload and prescale, flag clear, then run
	task automatic setup(input logic [2:0] p, input logic xt,
		input logic [7:0] lo, input logic [7:0] arm);
		wr(`WUT_ADDR_CLK_ARM, {3'h0, xt, 4'h0});
		wr(`WUT_ADDR_PRESCALE, {5'h00, p});
		wr(`WUT_ADDR_RELOAD_LO, lo);
		wr(`WUT_ADDR_RELOAD_HI, 8'h00);
		wr(`WUT_ADDR_CTRL, 8'h01);
		wr(`WUT_ADDR_CTRL, 8'h00);
		wr(`WUT_ADDR_CLK_ARM, arm | {3'h0, xt, 4'h8});
	endtask : setup

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int n;
		repeat (16) @(negedge ref_clk);
		srst = 0;
		for (int a = 'h316; a <= 'h31d; a++)
			rd(a[10:0], 8'h00);
		wr(`WUT_ADDR_PRESCALE, 8'h05);
		rd(`WUT_ADDR_PRESCALE, 8'h05);
		wr(`WUT_ADDR_RELOAD_HI, 8'h5a);
		rd(`WUT_ADDR_RELOAD_HI, 8'h5a);
		wr(11'h300, 8'hff);
		rd(11'h300, 8'h00);
		$display("register test done");
		// Reload 1: flag appears on exactly the Nth slow edge
		for (int i = 0; i < 6; i++) begin
			setup(i[2:0], i[0], 8'h01, 8'h00);
			repeat (divs[i] - 1) slow_edge(i[0]);
			rd(`WUT_ADDR_OSC_STATUS, 8'h00);
			slow_edge(i[0]);
			rd(`WUT_ADDR_OSC_STATUS, 8'h02);
		end
		$display("prescaler test done");
		// The RC clock times the sleep tests, so it is calibrated first;
		// the flag from the last prescaler run is still standing
		wr(`WUT_ADDR_CTRL, 8'h00);
		wr(`WUT_ADDR_CTRL, 8'h02);
		rd(`WUT_ADDR_OSC_STATUS, 8'h02);
		repeat (CAL) @(negedge ref_clk);
		rd(`WUT_ADDR_OSC_STATUS, 8'h03);
		$display("calibration test done");
		wr(`WUT_ADDR_LINE1_EN, 8'h01);
		wr(`WUT_ADDR_LINE2_EN, 8'h00);
		setup(3'h0, 1'b0, 8'h02, 8'h80);
		cmd(8'hb2);
		check({7'h0, sleeping}, 8'h00);
		cmd(`WUT_CMD_SLEEP);
		check({7'h0, sleeping}, 8'h01);
		slow_edge(1'b0);
		check({5'h0, irq2, irq1, sleeping}, 8'h01);
		rc_clk = 1;
		n = 0;
		while (wake_event !== 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		check({7'h0, wake_event}, 8'h01);
		if (n == 40)
			report_and_stop();
		repeat (8) @(negedge ref_clk);
		rc_clk = 0;
		check({5'h0, irq2, irq1, sleeping}, 8'h02);
		rd(`WUT_ADDR_OSC_STATUS, 8'h03);
		wr(`WUT_ADDR_CTRL, 8'h01);
		wr(`WUT_ADDR_CTRL, 8'h00);
		rd(`WUT_ADDR_OSC_STATUS, 8'h01);
		check({6'h0, irq2, irq1}, 8'h00);
		wr(`WUT_ADDR_LINE1_EN, 8'h00);
		wr(`WUT_ADDR_LINE2_EN, 8'h01);
		// Zero tick reloads, then two more ticks reach zero again
		repeat (2) slow_edge(1'b0);
		check({6'h0, irq2, irq1}, 8'h00);
		slow_edge(1'b0);
		check({5'h0, irq2, irq1, sleeping}, 8'h04);
		$display("sleep and interrupt test done");
		// Without the arm bit a timeout raises the flag but keeps sleep
		setup(3'h0, 1'b0, 8'h01, 8'h00);
		cmd(`WUT_CMD_SLEEP);
		slow_edge(1'b0);
		check({5'h0, irq2, irq1, sleeping}, 8'h05);
		$display("unarmed sleep test done");
		report_and_stop();
	end
endmodule : test_wakeup_timer_unit

// ---- wut_monitor.sv ----
// Port-level checker for the wake-up timer unit top.
// Assumes one ref_clk domain and a synchronous active-high srst.
`timescale 1ns/10ps
module wut_monitor (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic reg_wr,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic irq1,
	input wire logic irq2,
	input wire logic sleeping,
	input wire logic wake_event
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////
	// Sleep entry and exit
	AST_SLEEP_ENTER: assert property (
		cmd_valid && cmd_code == 8'hb1 |=> sleeping)
		else $error("sleep command not taken");
	AST_SLEEP_CAUSE: assert property (
		$rose(sleeping) |-> $past(cmd_valid) && $past(cmd_code) == 8'hb1)
		else $error("sleep entered without command");
	AST_AWAKE_STAYS: assert property (
		!sleeping && !cmd_valid |=> !sleeping)
		else $error("sleep entered spontaneously");
	AST_WAKE_ONE: assert property (
		wake_event |=> !wake_event)
		else $error("wake pulse longer than one cycle");
	AST_WAKE_LEAVES: assert property (
		wake_event |-> !sleeping && $past(sleeping))
		else $error("wake pulse without leaving sleep");
	AST_SLEEP_EXIT: assert property (
		$fell(sleeping) |-> wake_event)
		else $error("sleep left without wake pulse");

	////////////////////////////////////////////////////////////////////////
	// A raised interrupt only drops after a host write
	AST_IRQ1_HOLD: assert property (
		$fell(irq1) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("irq1 dropped without host write");
	AST_IRQ2_HOLD: assert property (
		$fell(irq2) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("irq2 dropped without host write");

	// Main scenarios reached
	cover property ($rose(sleeping));
	cover property (wake_event);
	cover property ($rose(irq1));
	cover property ($rose(irq2));
endmodule : wut_monitor

bind wut_top wut_monitor u_mon (.ref_clk(ref_clk), .srst(srst),
	.reg_wr(reg_wr), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
	.irq1(irq1), .irq2(irq2), .sleeping(sleeping),
	.wake_event(wake_event));

// ---- wut_pkg.sv ----
// Types shared by the wake-up timer unit modules.
// Assumes wut_regs.svh supplies all numeric constants.
package wut_pkg;

	typedef logic [2:0] wut_presc_type;
	typedef logic [15:0] wut_count_type;
	typedef enum logic [1:0] {
		WUT_CAL_IDLE,
		WUT_CAL_BUSY,
		WUT_CAL_DONE
	} wut_cal_state_type;

endpackage : wut_pkg

// ---- wut_prescaler.sv ----
// Programmable prescaler dividing the slow tick by 1..65536.
// Assumes slow_tick is a one-cycle pulse on ref_clk.
`timescale 1ns/10ps
module wut_prescaler
	import wut_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	wut_tick_if.presc tick
);

	logic [16:0] div_cnt_q;
	logic [16:0] div_last;

	// Division minus one for each prescaler code
	function automatic logic [16:0] wut_div_last(input wut_presc_type sel);
		case (sel)
			3'h0: wut_div_last = 17'h00000;
			3'h1: wut_div_last = 17'h00003;
			3'h2: wut_div_last = 17'h00007;
			3'h3: wut_div_last = 17'h0000f;
			3'h4: wut_div_last = 17'h0007f;
			3'h5: wut_div_last = 17'h003ff;
			3'h6: wut_div_last = 17'h01fff;
			default: wut_div_last = 17'h0ffff;
		endcase
	endfunction : wut_div_last

	assign div_last = wut_div_last(tick.presc_sel); // [RL5]

	////////////////////////////////////////////////////////////////////
	// Divider counts slow ticks; a restart lines the phase up with a load
	always_ff @(posedge ref_clk) begin
		if (srst || tick.restart) begin
			div_cnt_q <= 17'h00000;
		end else if (tick.slow_tick) begin
			if (div_cnt_q >= div_last) begin
				div_cnt_q <= 17'h00000;
			end else begin
				div_cnt_q <= div_cnt_q + 17'h00001;
			end
		end
	end

	// One output pulse per division period
	assign tick.prescaled_tick = tick.slow_tick && !tick.restart &&
		(div_cnt_q >= div_last); // [RL4]

endmodule : wut_prescaler

// ---- wut_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// of the wake-up timer unit. Definitions only.
`ifndef WUT_REGS_SVH
`define WUT_REGS_SVH

// Register offsets on the 11-bit register port
`define WUT_ADDR_PRESCALE 11'h316
`define WUT_ADDR_CLK_ARM 11'h317
`define WUT_ADDR_RELOAD_LO 11'h318
`define WUT_ADDR_RELOAD_HI 11'h319
`define WUT_ADDR_CTRL 11'h31a
`define WUT_ADDR_OSC_STATUS 11'h31b
`define WUT_ADDR_LINE1_EN 11'h31c
`define WUT_ADDR_LINE2_EN 11'h31d

// Field positions
`define WUT_PRESCALE_LSB 0
`define WUT_SLEEP_CFG_LSB 3
`define WUT_SLEEP_CFG_RUN 3
`define WUT_SLEEP_CFG_XTAL 4
`define WUT_WAKE_ON_TIMEOUT 7
`define WUT_CTRL_FLAG_RESET 0
`define WUT_CTRL_RC_CAL 1
`define WUT_STATUS_CAL_DONE 0
`define WUT_STATUS_FLAG 1
`define WUT_EN_TIMEOUT 0

// Reset values
`define WUT_RESET_BYTE 8'h00
`define WUT_RESET_RELOAD 16'h0000

// Command and timing
`define WUT_CMD_SLEEP 8'hb1
`define WUT_CLK_MHZ 250
`define WUT_CAL_TIME_US 1

`endif

// ---- wut_tick_if.sv ----
// Carrier between the timer core and its prescaler.
// Assumes both ends run on ref_clk.
`timescale 1ns/10ps
interface wut_tick_if;
	import wut_pkg::*;
	logic slow_tick;
	logic restart;
	wut_presc_type presc_sel;
	logic prescaled_tick;

	modport core (output slow_tick, output restart, output presc_sel,
		input prescaled_tick);
	modport presc (input slow_tick, input restart, input presc_sel,
		output prescaled_tick);
endinterface : wut_tick_if

// ---- wut_top.sv ----
// Wake-up timer unit: slow-clock selection, prescaler, 16-bit down
// counter, timeout flag, interrupt routing, sleep exit, RC calibration.
// Assumes a byte register port from the command controller on ref_clk
// and asynchronous 32.768 kHz clocks arriving as plain inputs.
//
// Overview of operation
// [RL1] Wake-up timer uses a 16-bit counter ticked through a prescaler.
// [RL2] Tick is 32.768 kHz from RC oscillator or external crystal.
// [RL3] Sleep clock field in second config register picks the source.
// [RL4] Selected tick feeds 3-bit prescaler clocking a 16-bit down counter.
// [RL5] Prescaler codes 0..7 divide by 1,4,8,16,128,1024,8192,65536.
// [RL6] Host selects clock first, then programs reload and prescaler.
// [RL7] Enabled counter loads reload value and decrements per tick.
// [RL8] Interrupt raised when the counter value becomes zero.
// [RL9] Timeout interrupt enabled per line, routable to either output.
// [RL10] Armed timer timeout takes the device out of sleep.
// [RL11] Host clears timeout flag by writing reset bit 1 then 0.
// [RL12] Host arms wake-up by writing 1 to wake-on-timeout.
// [RL13] Host sends sleep only after clock, reload, clear, arm steps.
// [RL14] No automatic RC calibration; host must start it.
// [RL15] Host starts calibration by writing cal bit 0 then 1.
// [RL16] Calibration may run anytime but must finish before sleep.
// [RL17] Calibration-ready bit goes high when calibration completes.
// [RL18] Host enters sleep with single-byte command 0xB1.
// [RL19] Timeout flag stays set until the host's reset sequence.
`timescale 1ns/10ps
`include "wut_regs.svh"
module wut_top
	import wut_pkg::*;
#(
	parameter int CAL_CYCLES = `WUT_CAL_TIME_US * `WUT_CLK_MHZ * 1000
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic rc_osc_clk,
	input wire logic xtal_osc_clk,
	input wire logic [10:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	output logic irq1,
	output logic irq2,
	output logic sleeping,
	output logic wake_event
);

	wut_tick_if tick ();

	logic [7:0] timer_prescale_config_q;
	logic [7:0] timer_clock_and_arm_config_q;
	logic [7:0] reload_value_low_q;
	logic [7:0] reload_value_high_q;
	logic [7:0] ctrl_q;
	logic [7:0] line1_event_enable_q;
	logic [7:0] line2_event_enable_q;
	logic [2:0] rc_sync_q;
	logic [2:0] xt_sync_q;
	logic rc_level_q;
	logic xt_level_q;
	logic run_q;
	wut_count_type count_q;
	logic timeout_flag_q;
	logic sleep_q;
	logic wake_q;
	logic [7:0] rdata_q;
	wut_cal_state_type cal_state_q;
	logic [17:0] cal_cnt_q;
	logic rc_calibration_done;
	logic run_en;
	logic use_xtal;
	logic load;
	logic hit_zero;
	logic flag_clear;
	logic cal_start;
	logic wr_ctrl;

	// Register write decode
	function automatic logic wut_wr_hit(input logic [10:0] a,
		input logic [10:0] target, input logic wr);
		wut_wr_hit = wr && (a == target);
	endfunction : wut_wr_hit

	////////////////////////////////////////////////////////////////////
	// Slow clock synchronisers; an edge counts once stages 2 and 3 agree
	// on the new level, so stage 1 never feeds logic directly
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rc_sync_q <= 3'h0;
			xt_sync_q <= 3'h0;
		end else begin
			rc_sync_q <= {rc_sync_q[1:0], rc_osc_clk};
			xt_sync_q <= {xt_sync_q[1:0], xtal_osc_clk};
		end
	end

	// Filtered level follows stages 2 and 3 only while they agree, so a
	// runt pulse caught by one stage alone never makes a tick
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rc_level_q <= 1'b0;
			xt_level_q <= 1'b0;
		end else begin
			if (rc_sync_q[1] == rc_sync_q[2]) begin
				rc_level_q <= rc_sync_q[2];
			end
			if (xt_sync_q[1] == xt_sync_q[2]) begin
				xt_level_q <= xt_sync_q[2];
			end
		end
	end

	assign run_en = timer_clock_and_arm_config_q[`WUT_SLEEP_CFG_RUN];
	assign use_xtal = timer_clock_and_arm_config_q[`WUT_SLEEP_CFG_XTAL];
	// Rising edge of the chosen oscillator gives one slow tick
	assign tick.slow_tick = run_q && (use_xtal ?
		(xt_sync_q[1] && xt_sync_q[2] && !xt_level_q) :
		(rc_sync_q[1] && rc_sync_q[2] && !rc_level_q)); // [RL2] [RL3]
	assign tick.presc_sel =
		timer_prescale_config_q[`WUT_PRESCALE_LSB +: 3]; // [RL5]
	assign tick.restart = load;

	wut_prescaler u_prescaler (
		.ref_clk(ref_clk),
		.srst(srst),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////
	// Configuration registers written from the register port
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			timer_prescale_config_q <= `WUT_RESET_BYTE;
			timer_clock_and_arm_config_q <= `WUT_RESET_BYTE;
			reload_value_low_q <= `WUT_RESET_BYTE;
			reload_value_high_q <= `WUT_RESET_BYTE;
			ctrl_q <= `WUT_RESET_BYTE;
			line1_event_enable_q <= `WUT_RESET_BYTE;
			line2_event_enable_q <= `WUT_RESET_BYTE;
		end else if (reg_wr) begin
			case (reg_addr)
				`WUT_ADDR_PRESCALE: timer_prescale_config_q <= reg_wdata;
				`WUT_ADDR_CLK_ARM: timer_clock_and_arm_config_q <= reg_wdata;
				`WUT_ADDR_RELOAD_LO: reload_value_low_q <= reg_wdata;
				`WUT_ADDR_RELOAD_HI: reload_value_high_q <= reg_wdata;
				`WUT_ADDR_CTRL: ctrl_q <= reg_wdata;
				`WUT_ADDR_LINE1_EN: line1_event_enable_q <= reg_wdata;
				`WUT_ADDR_LINE2_EN: line2_event_enable_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Counter load: on enable, and on a high-byte write while running,
	// so a host that programs the reload after the clock restarts cleanly
	assign load = (run_en && !run_q) || (run_en &&
		wut_wr_hit(reg_addr, `WUT_ADDR_RELOAD_HI, reg_wr));

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			run_q <= 1'b0;
		end else begin
			run_q <= run_en;
		end
	end

	// Down counter; reloads on the tick after zero for periodic wake
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			count_q <= `WUT_RESET_RELOAD;
		end else if (load) begin
			count_q <= {reload_value_high_q, reload_value_low_q}; // [RL7]
		end else if (tick.prescaled_tick) begin
			if (count_q == 16'h0000) begin
				count_q <= {reload_value_high_q, reload_value_low_q};
			end else begin
				count_q <= count_q - 16'h0001; // [RL1] [RL7]
			end
		end
	end

	assign hit_zero = tick.prescaled_tick && !load &&
		(count_q == 16'h0001); // [RL8]

	////////////////////////////////////////////////////////////////////
	// Timeout flag: a 0-to-1 write of the reset bit clears it; a zero
	// arriving in the same cycle still sets it
	assign wr_ctrl = wut_wr_hit(reg_addr, `WUT_ADDR_CTRL, reg_wr);
	assign flag_clear = wr_ctrl && reg_wdata[`WUT_CTRL_FLAG_RESET] &&
		!ctrl_q[`WUT_CTRL_FLAG_RESET]; // [RL11]

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			timeout_flag_q <= 1'b0;
		end else if (hit_zero) begin
			timeout_flag_q <= 1'b1; // [RL8]
		end else if (flag_clear) begin
			timeout_flag_q <= 1'b0; // [RL19]
		end
	end

	// Interrupt lines, each with its own enable
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq1 <= 1'b0;
			irq2 <= 1'b0;
		end else begin
			irq1 <= timeout_flag_q &&
				line1_event_enable_q[`WUT_EN_TIMEOUT]; // [RL9]
			irq2 <= timeout_flag_q &&
				line2_event_enable_q[`WUT_EN_TIMEOUT]; // [RL9]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sleep state: entered by command, left on an armed timeout
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sleep_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			wake_q <= 1'b0;
			if (sleep_q && hit_zero &&
				timer_clock_and_arm_config_q[`WUT_WAKE_ON_TIMEOUT]) begin
				sleep_q <= 1'b0; // [RL10]
				wake_q <= 1'b1;
			end else if (cmd_valid && cmd_code == `WUT_CMD_SLEEP) begin
				sleep_q <= 1'b1; // [RL18]
			end
		end
	end

	assign sleeping = sleep_q;
	assign wake_event = wake_q;

	////////////////////////////////////////////////////////////////////
	// RC calibration runs only when the host raises the trigger bit;
	// the oscillator model here is a fixed-length busy period
	assign cal_start = wr_ctrl && reg_wdata[`WUT_CTRL_RC_CAL] &&
		!ctrl_q[`WUT_CTRL_RC_CAL]; // [RL14] [RL15]

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cal_state_q <= WUT_CAL_IDLE;
			cal_cnt_q <= 18'h00000;
		end else if (cal_start) begin
			cal_state_q <= WUT_CAL_BUSY;
			cal_cnt_q <= 18'h00000;
		end else begin
			case (cal_state_q)
				WUT_CAL_BUSY: begin
					if (cal_cnt_q >= 18'(CAL_CYCLES - 1)) begin
						cal_state_q <= WUT_CAL_DONE; // [RL17]
					end else begin
						cal_cnt_q <= cal_cnt_q + 18'h00001;
					end
				end
				WUT_CAL_DONE: cal_state_q <= WUT_CAL_DONE;
				default: cal_state_q <= WUT_CAL_IDLE;
			endcase
		end
	end

	assign rc_calibration_done = (cal_state_q == WUT_CAL_DONE); // [RL17]

	////////////////////////////////////////////////////////////////////
	// Read data registered on a read strobe; unmapped offsets read zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`WUT_ADDR_PRESCALE: rdata_q <= timer_prescale_config_q;
				`WUT_ADDR_CLK_ARM: rdata_q <= timer_clock_and_arm_config_q;
				`WUT_ADDR_RELOAD_LO: rdata_q <= reload_value_low_q;
				`WUT_ADDR_RELOAD_HI: rdata_q <= reload_value_high_q;
				`WUT_ADDR_CTRL: rdata_q <= ctrl_q;
				`WUT_ADDR_OSC_STATUS: rdata_q <= {6'h00, timeout_flag_q,
					rc_calibration_done};
				`WUT_ADDR_LINE1_EN: rdata_q <= line1_event_enable_q;
				`WUT_ADDR_LINE2_EN: rdata_q <= line2_event_enable_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = rdata_q;

endmodule : wut_top
